/* File: hw/cond_check.sv */
/*
  Condition evaluator for instructions inside a conditional block.
  Purely combinational; flags come from logic on the same clock.
*/
`timescale 1ns/1ps
module cond_check (
  // Condition code, low bit inverts the base test
  input wire logic [3:0] cond_i,
  // Flags N, Z, C, V
  input wire logic [3:0] nzcv_i,
  // Result
  output logic pass_o
);

  logic n;
  logic z;
  logic c;
  logic v;
  logic base;

  assign n = nzcv_i[3];
  assign z = nzcv_i[2];
  assign c = nzcv_i[1];
  assign v = nzcv_i[0];

  always_comb begin
    unique case (cond_i[3:1])
      3'h0: base = z;
      3'h1: base = c;
      3'h2: base = n;
      3'h3: base = v;
      3'h4: base = c & ~z;
      3'h5: base = (n == v);
      3'h6: base = (n == v) & ~z;
      3'h7: base = 1'b1;
    endcase
  end

  // Odd codes are the inverse of their even base, except always
  assign pass_o = (cond_i == 4'hF) ? 1'b1 : (base ^ cond_i[0]);

endmodule : cond_check

/* File: hw/exec_state_pkg.sv */
/*
  Constants, state type and packing helpers for the execution-state unit:
  field positions and reset values of the combined status word.
  Assumes a single core clock domain; no bus, fields travel on plain ports.
*/
package exec_state_pkg;

  // ==========================================================================
  // Field positions of the combined status word
  localparam int PSR_W = 32;
  localparam int SAT_BIT = 27;
  localparam int ST_HI_MSB = 26;
  localparam int ST_HI_LSB = 25;
  localparam int TBIT_POS = 24;
  localparam int RSV_HI_MSB = 23;
  localparam int RSV_HI_LSB = 16;
  localparam int ST_LO_MSB = 15;
  localparam int ST_LO_LSB = 10;
  localparam int REG_MSB = 15;
  localparam int REG_LSB = 12;
  localparam int RSV_LO_MSB = 9;
  localparam int RSV_LO_LSB = 6;

  // ==========================================================================
  // Reset values and fixed encodings
  localparam logic [7:0] ST_CLEAR = 8'h00;
  localparam logic TBIT_RST = 1'b1;
  localparam logic SAT_RST = 1'b0;
  localparam logic [3:0] REG_NONE = 4'h0;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [2:0] LAST_SLOT = 3'h0;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] BLOCK_MAX = 3'h4;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {EX_IDLE, EX_COND, EX_XFER} ex_mode_t;

  // ==========================================================================
  // Packing of the 8-bit state into the split fields
  // st[7:2] sits at word bits 15:10, st[1:0] at word bits 26:25
  function automatic logic [31:0] pack_psr(input logic q,
                                           input logic t,
                                           input logic [7:0] st);
    logic [31:0] w;
    w = WORD_ZERO;
    w[SAT_BIT] = q;
    w[TBIT_POS] = t;
    w[ST_HI_MSB:ST_HI_LSB] = st[1:0];
    w[ST_LO_MSB:ST_LO_LSB] = st[7:2];
    return w;
  endfunction : pack_psr

  function automatic logic [7:0] st_of_psr(input logic [31:0] w);
    return {w[ST_LO_MSB:ST_LO_LSB], w[ST_HI_MSB:ST_HI_LSB]};
  endfunction : st_of_psr

  // Transfer state: register number in the top nibble, the rest zero
  function automatic logic [7:0] xfer_state(input logic [3:0] reg_num);
    return {reg_num, MASK_NONE};
  endfunction : xfer_state

  // Step the block state past one instruction
  function automatic logic [7:0] cond_advance(input logic [7:0] st);
    if (st[2:0] == LAST_SLOT) begin
      return ST_CLEAR;
    end
    return {st[7:5], st[3:0], 1'b0};
  endfunction : cond_advance

endpackage : exec_state_pkg

/* File: hw/exec_state_unit.sv */
/*
  Execution-state part of the combined status word: instruction-set state
  bit, split transfer / conditional-block state, saturation flag.
  Assumes the core drives all event inputs on clk_i, one cycle each, and
  stacks psr_o on the cycle it raises vector_load_i.
*/
`timescale 1ns/1ps
// How it works
// - Read-only split state field at bits 26:25 and 15:10.
// - Transfer state keeps bits 26:25 at zero.
// - Suspended transfer records next register number in bits 15:12.
// - Return resumes transfer at register held in bits 15:12.
// - Up to four instructions after block start are conditional.
// - Block conditions are the base condition or its inverse.
// - State bit 24 is read-only and resets to one.
// - Exchange branches and program-counter pops load bit 24 from target.
// - Exception return restores bit 24 from the stacked word.
// - Exception entry or reset loads bit 24 from vector bit 0.
// - Executing with bit 24 clear raises fault or lockup.
// - Execution fields meaningful only in combined or execution view.
// - Software move reads return zero there; writes are ignored.
// - Saturation flag at bit 27 sets on overflow and sticks.
module exec_state_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Exception entry, reset vector and return
  input wire logic vector_load_i,
  input wire logic vector_bit0_i,
  input wire logic exc_return_i,
  input wire logic ret_is_xfer_i,
  input wire logic [31:0] stacked_psr_i,
  // Branches that may change the state bit
  input wire logic branch_i,
  input wire logic branch_target0_i,
  // Conditional block
  input wire logic cb_start_i,
  input wire logic [7:0] cb_state_i,
  input wire logic instr_exec_i,
  input wire logic in_handler_i,
  input wire logic [3:0] nzcv_i,
  // Multi-register transfer
  input wire logic mt_suspend_i,
  input wire logic [3:0] mt_next_reg_i,
  input wire logic mt_done_i,
  // Saturation and software access
  input wire logic sat_event_i,
  input wire logic sw_wr_i,
  input wire logic sw_wr_app_i,
  input wire logic [31:0] sw_wr_data_i,
  input wire logic sw_rd_i,
  input wire logic sw_rd_app_i,
  // Status word and results
  output logic [31:0] psr_o,
  output logic [31:0] sw_rd_data_o,
  output logic in_block_o,
  output logic skip_o,
  output logic resume_o,
  output logic [3:0] resume_reg_o,
  output logic fault_o,
  output logic lockup_o
);

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_ff;
  logic rstn;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rstn = rst_sync_ff[1];

  // ==========================================================================
  // Execution state machine
  exec_state_pkg::ex_mode_t mode_ff, nxt_mode;
  logic [7:0] st_ff, nxt_st, st_step, st_ret;
  logic skip_ff, nxt_skip, resume_ff, nxt_resume;
  logic in_block_ff, nxt_in_block, cond_pass;
  logic [3:0] resume_reg_ff, nxt_resume_reg;

  cond_check u_cond (
    .cond_i(st_ff[7:4]),
    .nzcv_i(nzcv_i),
    .pass_o(cond_pass)
  );

  assign st_step = exec_state_pkg::cond_advance(st_ff);
  assign st_ret = exec_state_pkg::st_of_psr(stacked_psr_i);

  always_comb begin
    nxt_mode = mode_ff;
    nxt_st = st_ff;
    nxt_skip = 1'b0;
    nxt_resume = 1'b0;
    nxt_resume_reg = resume_reg_ff;
    if (vector_load_i) begin
      nxt_mode = exec_state_pkg::EX_IDLE;
      nxt_st = exec_state_pkg::ST_CLEAR;
    end else if (exc_return_i) begin
      if (ret_is_xfer_i) begin
        nxt_mode = exec_state_pkg::EX_XFER;
        nxt_st = exec_state_pkg::xfer_state(
          stacked_psr_i[exec_state_pkg::REG_MSB:exec_state_pkg::REG_LSB]);
        nxt_resume = 1'b1;
        nxt_resume_reg =
          stacked_psr_i[exec_state_pkg::REG_MSB:exec_state_pkg::REG_LSB];
      end else begin
        nxt_st = st_ret;
        nxt_mode = (st_ret == exec_state_pkg::ST_CLEAR) ?
                   exec_state_pkg::EX_IDLE : exec_state_pkg::EX_COND;
      end
    end else if (mt_suspend_i) begin
      nxt_mode = exec_state_pkg::EX_XFER;
      nxt_st = exec_state_pkg::xfer_state(mt_next_reg_i);
    end else begin
      unique case (mode_ff)
        exec_state_pkg::EX_IDLE: begin
          if (cb_start_i && cb_state_i[3:0] != exec_state_pkg::MASK_NONE) begin
            nxt_mode = exec_state_pkg::EX_COND;
            nxt_st = cb_state_i;
          end
        end
        exec_state_pkg::EX_COND: begin
          if (instr_exec_i) begin
            nxt_skip = ~cond_pass;
            nxt_st = st_step;
            if (st_step == exec_state_pkg::ST_CLEAR) begin
              nxt_mode = exec_state_pkg::EX_IDLE;
            end
          end
        end
        exec_state_pkg::EX_XFER: begin
          if (mt_done_i) begin
            nxt_mode = exec_state_pkg::EX_IDLE;
            nxt_st = exec_state_pkg::ST_CLEAR;
          end
        end
        default: begin
          nxt_mode = exec_state_pkg::EX_IDLE;
          nxt_st = exec_state_pkg::ST_CLEAR;
        end
      endcase
    end
    nxt_in_block = (nxt_mode == exec_state_pkg::EX_COND);
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= exec_state_pkg::EX_IDLE;
      st_ff <= exec_state_pkg::ST_CLEAR;
      skip_ff <= 1'b0;
      resume_ff <= 1'b0;
      resume_reg_ff <= exec_state_pkg::REG_NONE;
      in_block_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      st_ff <= nxt_st;
      skip_ff <= nxt_skip;
      resume_ff <= nxt_resume;
      resume_reg_ff <= nxt_resume_reg;
      in_block_ff <= nxt_in_block;
    end
  end

  // ==========================================================================
  // State bit, saturation flag, faults
  logic tbit_ff, nxt_tbit, q_ff, nxt_q;
  logic fault_ff, nxt_fault, lockup_ff, nxt_lockup;

  always_comb begin
    nxt_tbit = tbit_ff;
    if (vector_load_i) begin
      nxt_tbit = vector_bit0_i;
    end else if (exc_return_i) begin
      nxt_tbit = stacked_psr_i[exec_state_pkg::TBIT_POS];
    end else if (branch_i) begin
      nxt_tbit = branch_target0_i;
    end
    // software clears by writing the flags view
    nxt_q = q_ff;
    if (sw_wr_i && sw_wr_app_i) begin
      nxt_q = sw_wr_data_i[exec_state_pkg::SAT_BIT];
    end
    if (sat_event_i) begin
      nxt_q = 1'b1;
    end
    // fault, plus sticky lockup when already handling
    nxt_fault = instr_exec_i & ~tbit_ff;
    nxt_lockup = lockup_ff | (nxt_fault & in_handler_i);
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      tbit_ff <= exec_state_pkg::TBIT_RST;
      q_ff <= exec_state_pkg::SAT_RST;
      fault_ff <= 1'b0;
      lockup_ff <= 1'b0;
    end else begin
      tbit_ff <= nxt_tbit;
      q_ff <= nxt_q;
      fault_ff <= nxt_fault;
      lockup_ff <= nxt_lockup;
    end
  end

  // ==========================================================================
  // Status word and software read view
  logic [31:0] psr_ff, nxt_psr, rd_ff, nxt_rd;

  always_comb begin
    // read-only split field, reserved at zero
    nxt_psr = exec_state_pkg::pack_psr(nxt_q, nxt_tbit, nxt_st);
    // execution bits read as zero to software
    // only the saturation flag shows here
    nxt_rd = rd_ff;
    if (sw_rd_i) begin
      nxt_rd = exec_state_pkg::WORD_ZERO;
      nxt_rd[exec_state_pkg::SAT_BIT] = sw_rd_app_i & q_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      psr_ff <= exec_state_pkg::pack_psr(exec_state_pkg::SAT_RST,
                                         exec_state_pkg::TBIT_RST,
                                         exec_state_pkg::ST_CLEAR);
      rd_ff <= exec_state_pkg::WORD_ZERO;
    end else begin
      psr_ff <= nxt_psr;
      rd_ff <= nxt_rd;
    end
  end

  assign psr_o = psr_ff;
  assign sw_rd_data_o = rd_ff;
  assign in_block_o = in_block_ff;
  assign skip_o = skip_ff;
  assign resume_o = resume_ff;
  assign resume_reg_o = resume_reg_ff;
  assign fault_o = fault_ff;
  assign lockup_o = lockup_ff;

  // ==========================================================================
  // Checks
  logic [2:0] blk_cnt_ff;
  logic higher;

  assign higher = vector_load_i | exc_return_i | mt_suspend_i;
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      blk_cnt_ff <= exec_state_pkg::CNT_ZERO;
    end else if (mode_ff != exec_state_pkg::EX_COND || higher) begin
      blk_cnt_ff <= exec_state_pkg::CNT_ZERO;
    end else if (instr_exec_i) begin
      blk_cnt_ff <= blk_cnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn);

  sequence s_suspend;
    mt_suspend_i && !vector_load_i && !exc_return_i;
  endsequence
  sequence s_ret_xfer;
    exc_return_i && ret_is_xfer_i && !vector_load_i;
  endsequence

  a_xfer_hi_zero: assert property (
    mode_ff == exec_state_pkg::EX_XFER |-> psr_o[26:25] == 2'h0)
    else $error("transfer state with bits 26:25 set");
  a_xfer_lo_zero: assert property (
    s_suspend |=> psr_o[11:10] == 2'h0 && mode_ff == exec_state_pkg::EX_XFER)
    else $error("transfer state with bits 11:10 set");
  a_suspend_reg: assert property (
    s_suspend |=> psr_o[15:12] == $past(mt_next_reg_i))
    else $error("suspended register number not recorded");
  a_resume_reg: assert property (
    s_ret_xfer |=> resume_o && resume_reg_o == $past(stacked_psr_i[15:12])
    ##1 (!resume_o || $past(exc_return_i)))
    else $error("resume pulse or register wrong");
  a_block_len: assert property (
    blk_cnt_ff <= exec_state_pkg::BLOCK_MAX)
    else $error("conditional block longer than four");
  a_skip_cond: assert property (
    mode_ff == exec_state_pkg::EX_COND && instr_exec_i && !higher
    |=> skip_o == !$past(cond_pass))
    else $error("skip does not follow condition");
  a_tbit_branch: assert property (
    branch_i && !vector_load_i && !exc_return_i
    |=> psr_o[24] == $past(branch_target0_i))
    else $error("branch did not load state bit");
  a_tbit_return: assert property (
    exc_return_i && !vector_load_i |=> psr_o[24] == $past(stacked_psr_i[24]))
    else $error("return did not restore state bit");
  a_tbit_vector: assert property (
    vector_load_i |=> psr_o[24] == $past(vector_bit0_i) &&
    psr_o[15:10] == 6'h0)
    else $error("vector bit 0 not loaded");
  a_fault_raise: assert property (
    instr_exec_i && !psr_o[24] |=> fault_o
    ##1 (lockup_o || !$past(in_handler_i, 2)))
    else $error("no fault with state bit clear");
  a_rsv_zero: assert property (
    psr_o[23:16] == 8'h0 && psr_o[9:6] == 4'h0)
    else $error("reserved bits not zero");
  a_sw_zero: assert property (
    sw_rd_i |=> sw_rd_data_o[26:24] == 3'h0 && sw_rd_data_o[15:10] == 6'h0)
    else $error("software read shows execution bits");
  a_sat_sticky: assert property (
    sat_event_i |=> psr_o[27] ##1 (psr_o[27] || $past(sw_wr_i)))
    else $error("saturation flag not sticky");
  a_block_clear: assert property (
    mode_ff == exec_state_pkg::EX_COND && instr_exec_i && !higher &&
    st_ff[2:0] == 3'h0 |=> psr_o[26:25] == 2'h0 && psr_o[15:10] == 6'h0)
    else $error("state not cleared at block end");

endmodule : exec_state_unit

/* File: sim/tb.sv */
/*
  Self-checking bench for the execution-state unit: event pulses are
  driven on the ports, the status word and result outputs are compared.
  Assumes the core-side contract: one-cycle pulses, answer one edge later.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Clock, reset and ports
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic vector_load_i = 1'b0, vector_bit0_i = 1'b0, exc_return_i = 1'b0;
  logic ret_is_xfer_i = 1'b0, branch_i = 1'b0, branch_target0_i = 1'b0;
  logic [31:0] stacked_psr_i = 32'h0000_0000;
  logic cb_start_i = 1'b0, instr_exec_i = 1'b0, in_handler_i = 1'b0;
  logic [7:0] cb_state_i = 8'h00;
  logic [3:0] nzcv_i = 4'h0, mt_next_reg_i = 4'h0;
  logic mt_suspend_i = 1'b0, mt_done_i = 1'b0, sat_event_i = 1'b0;
  logic sw_wr_i = 1'b0, sw_wr_app_i = 1'b0, sw_rd_i = 1'b0;
  logic sw_rd_app_i = 1'b0;
  logic [31:0] sw_wr_data_i = 32'h0000_0000;
  logic [31:0] psr_o, sw_rd_data_o;
  logic in_block_o, skip_o, resume_o, fault_o, lockup_o;
  logic [3:0] resume_reg_o;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  localparam int k_vec = 0, k_ret = 1, k_br = 2, k_cb = 3, k_ex = 4;
  localparam int k_sus = 5, k_done = 6, k_sat = 7, k_wr = 8, k_rd = 9;
  logic [7:0] steps [4] = '{8'h12, 8'h04, 8'h08, 8'h00};
  logic skips [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  always #12.5 clk_i = ~clk_i;

  exec_state_unit u_exec_state_unit (
    .clk_i(clk_i), .resetn_i(resetn_i), .vector_load_i(vector_load_i),
    .vector_bit0_i(vector_bit0_i), .exc_return_i(exc_return_i),
    .ret_is_xfer_i(ret_is_xfer_i), .stacked_psr_i(stacked_psr_i),
    .branch_i(branch_i), .branch_target0_i(branch_target0_i),
    .cb_start_i(cb_start_i), .cb_state_i(cb_state_i),
    .instr_exec_i(instr_exec_i), .in_handler_i(in_handler_i),
    .nzcv_i(nzcv_i), .mt_suspend_i(mt_suspend_i),
    .mt_next_reg_i(mt_next_reg_i), .mt_done_i(mt_done_i),
    .sat_event_i(sat_event_i), .sw_wr_i(sw_wr_i),
    .sw_wr_app_i(sw_wr_app_i), .sw_wr_data_i(sw_wr_data_i),
    .sw_rd_i(sw_rd_i), .sw_rd_app_i(sw_rd_app_i), .psr_o(psr_o),
    .sw_rd_data_o(sw_rd_data_o), .in_block_o(in_block_o),
    .skip_o(skip_o), .resume_o(resume_o), .resume_reg_o(resume_reg_o),
    .fault_o(fault_o), .lockup_o(lockup_o)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] word(input logic q, input logic t,
                                       input logic [7:0] st);
    return {4'h0, q, st[1:0], t, 8'h00, st[7:2], 10'h000};
  endfunction : word

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One event pulse, sampled at the next edge, outputs settled after it
  task automatic ev(input int k, input logic [31:0] a, input logic b);
    @(posedge clk_i);
    case (k)
      k_vec: begin
        vector_load_i <= 1'b1;
        vector_bit0_i <= a[0];
      end
      k_ret: begin
        exc_return_i <= 1'b1;
        stacked_psr_i <= a;
        ret_is_xfer_i <= b;
      end
      k_br: begin
        branch_i <= 1'b1;
        branch_target0_i <= a[0];
      end
      k_cb: begin
        cb_start_i <= 1'b1;
        cb_state_i <= a[7:0];
      end
      k_ex: begin
        instr_exec_i <= 1'b1;
        nzcv_i <= a[3:0];
      end
      k_sus: begin
        mt_suspend_i <= 1'b1;
        mt_next_reg_i <= a[3:0];
      end
      k_done: mt_done_i <= 1'b1;
      k_sat: sat_event_i <= 1'b1;
      k_wr: begin
        sw_wr_i <= 1'b1;
        sw_wr_data_i <= a;
        sw_wr_app_i <= b;
      end
      default: begin
        sw_rd_i <= 1'b1;
        sw_rd_app_i <= b;
      end
    endcase
    @(posedge clk_i);
    {vector_load_i, exc_return_i, branch_i, cb_start_i, instr_exec_i} <= '0;
    {mt_suspend_i, mt_done_i, sat_event_i, sw_wr_i, sw_rd_i} <= '0;
    #1;
  endtask : ev

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    do_reset();
    chk(psr_o, 32'h0100_0000);
    chk({in_block_o, fault_o, lockup_o, resume_o}, 32'h0);
    $display("test reset done");
    // Block of four: EQ, NE, EQ, EQ with Z clear
    ev(k_cb, 32'h09, 1'b0);
    chk(psr_o, word(1'b0, 1'b1, 8'h09));
    chk(in_block_o, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ev(k_ex, 32'h0, 1'b0);
      chk(skip_o, skips[i]);
      chk(psr_o, word(1'b0, 1'b1, steps[i]));
    end
    chk(in_block_o, 32'h0);
    $display("test block done");
    ev(k_sus, 32'h5, 1'b0);
    chk(psr_o, word(1'b0, 1'b1, 8'h50));
    chk(psr_o[26:25], 32'h0);
    chk(psr_o[11:10], 32'h0);
    ev(k_vec, 32'h1, 1'b0);
    chk(psr_o, word(1'b0, 1'b1, 8'h00));
    ev(k_ret, word(1'b0, 1'b1, 8'h50), 1'b1);
    chk(resume_o, 32'h1);
    chk(resume_reg_o, 32'h5);
    chk(psr_o[15:12], 32'h5);
    @(posedge clk_i);
    #1;
    chk(resume_o, 32'h0);
    ev(k_done, 32'h0, 1'b0);
    chk(psr_o, word(1'b0, 1'b1, 8'h00));
    $display("test transfer done");
    ev(k_br, 32'h0, 1'b0);
    chk(psr_o[24], 32'h0);
    ev(k_ex, 32'h0, 1'b0);
    chk({fault_o, lockup_o}, 32'h2);
    ev(k_br, 32'h1, 1'b0);
    chk(psr_o[24], 32'h1);
    ev(k_ret, word(1'b0, 1'b0, 8'h00), 1'b0);
    chk(psr_o[24], 32'h0);
    ev(k_vec, 32'h1, 1'b0);
    chk(psr_o[24], 32'h1);
    ev(k_ret, 32'h01FF_FFFF, 1'b0);
    chk({psr_o[23:16], psr_o[9:6]}, 32'h0);
    chk(psr_o, word(1'b0, 1'b1, 8'hFC));
    chk(in_block_o, 32'h1);
    ev(k_vec, 32'h1, 1'b0);
    $display("test state bit done");
    ev(k_sat, 32'h0, 1'b0);
    repeat (3) @(posedge clk_i);
    #1;
    chk(psr_o, word(1'b1, 1'b1, 8'h00));
    ev(k_rd, 32'h0, 1'b1);
    chk(sw_rd_data_o, 32'h0800_0000);
    ev(k_rd, 32'h0, 1'b0);
    chk(sw_rd_data_o, 32'h0);
    ev(k_cb, 32'h08, 1'b0);
    ev(k_wr, 32'hF7FF_FFFF, 1'b1);
    chk(psr_o, word(1'b0, 1'b1, 8'h08));
    ev(k_ex, 32'h4, 1'b0);
    chk({in_block_o, skip_o}, 32'h0);
    $display("test software access done");
    ev(k_vec, 32'h0, 1'b0);
    chk(psr_o[24], 32'h0);
    @(posedge clk_i);
    in_handler_i <= 1'b1;
    ev(k_ex, 32'h0, 1'b0);
    repeat (4) @(posedge clk_i);
    #1;
    chk(lockup_o, 32'h1);
    @(posedge clk_i);
    in_handler_i <= 1'b0;
    do_reset();
    chk(psr_o, 32'h0100_0000);
    chk(lockup_o, 32'h0);
    $display("test lockup and second reset done");
    tally_and_finish();
  end
endmodule : tb
